// *** hw/vrc_pkg.sv ***
// Functional notes
// - software switches the regulator on or off with a control bit
// - a mode bit picks normal operation or low-power suspend mode
// - mode bit zero means normal, one means low power
// - status bit shows the live synchronised vbus level, not latched
// - enabled vbus interrupt requests while vbus equals chosen polarity
// - the vbus interrupt keeps no pending flag and needs no clearing
// - interrupt request follows the match, dropping one clock after it ends
// - with usb as reset source, a polarity match raises system reset
// - polarity one matches high vbus, zero matches low vbus
package vrc_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0]  VRC_CTRL_OFF    = 8'h00;
	localparam logic [7:0]  VRC_IRQ_OFF     = 8'h04;
	localparam int          VRC_DIS_BIT     = 7;
	localparam int          VRC_STAT_BIT    = 6;
	localparam int          VRC_POL_BIT     = 5;
	localparam int          VRC_MODE_BIT    = 4;
	localparam int          VRC_IEN_BIT     = 0;
	localparam int          VRC_RSEN_BIT    = 1;
	localparam logic [31:0] VRC_CTRL_RST    = 32'h0000_0000;
	localparam logic [31:0] VRC_IRQ_RST     = 32'h0000_0000;
	localparam logic        VRC_MODE_NORMAL = 1'b0;
	localparam logic        VRC_MODE_LOWPWR = 1'b1;

endpackage

// *** hw/vrc_top.sv ***
`timescale 1ns/10ps
module vrc_top
	import vrc_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// vbus sense
	input  wire logic        vbus_in,
	// regulator and system
	output logic             regulator_enable_bit,
	output logic             regulator_low_power_select,
	output logic             vbus_irq,
	output logic             usb_sys_reset
);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic        sync1;
		logic        sync2;
		logic        dis;
		logic        ren;
		logic        pol;
		logic        mode;
		logic        ien;
		logic        rsen;
		logic        irq;
		logic        srst;
		logic        ready;
		logic        err;
		logic [31:0] rdata;
	} vrc_state_t;

	vrc_state_t st_q;
	vrc_state_t st_d;

	function automatic logic vrc_match(input logic lvl, input logic pol);
		return lvl == pol;
	endfunction

	logic setup;
	logic hit_ctrl;
	logic hit_irq;
	logic [31:0] rd_ctrl;
	logic [31:0] rd_irq;
	logic match_now;

	always_comb
	begin
		st_d = st_q;
		setup = psel && !penable;
		hit_ctrl = paddr == VRC_CTRL_OFF;
		hit_irq = paddr == VRC_IRQ_OFF;
		// two-stage synchroniser, second stage is the only reader
		st_d.sync1 = vbus_in;
		st_d.sync2 = st_q.sync1;
		match_now = vrc_match(st_q.sync2, st_q.pol);
		// level only, no sticky flag so nothing to clear
		st_d.irq = st_q.ien && match_now;
		st_d.srst = st_q.rsen && match_now;
		rd_ctrl = 32'h0000_0000;
		rd_ctrl[VRC_DIS_BIT] = st_q.dis;
		rd_ctrl[VRC_STAT_BIT] = st_q.sync2;
		rd_ctrl[VRC_POL_BIT] = st_q.pol;
		rd_ctrl[VRC_MODE_BIT] = st_q.mode;
		rd_irq = 32'h0000_0000;
		rd_irq[VRC_IEN_BIT] = st_q.ien;
		rd_irq[VRC_RSEN_BIT] = st_q.rsen;
		st_d.ready = 1'b0;
		st_d.err = 1'b0;
		// no wait state: answer in the cycle after setup
		if (setup)
		begin
			st_d.ready = 1'b1;
			st_d.err = !(hit_ctrl || hit_irq);
			st_d.rdata = 32'h0000_0000;
			if (!pwrite && hit_ctrl)
			begin
				st_d.rdata = rd_ctrl;
			end
			else if (!pwrite && hit_irq)
			begin
				st_d.rdata = rd_irq;
			end
		end
		if (psel && penable && st_q.ready && pwrite)
		begin
			if (hit_ctrl)
			begin
				st_d.dis = pwdata[VRC_DIS_BIT];
				st_d.pol = pwdata[VRC_POL_BIT];
				st_d.mode = pwdata[VRC_MODE_BIT];
			end
			else if (hit_irq)
			begin
				st_d.ien = pwdata[VRC_IEN_BIT];
				st_d.rsen = pwdata[VRC_RSEN_BIT];
			end
		end
		// own flop so the pin needs no inverter after the register
		st_d.ren = !st_d.dis;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			st_q <= '0;
			st_q.dis <= VRC_CTRL_RST[VRC_DIS_BIT];
			st_q.ren <= !VRC_CTRL_RST[VRC_DIS_BIT];
			st_q.pol <= VRC_CTRL_RST[VRC_POL_BIT];
			st_q.mode <= VRC_MODE_NORMAL;
			st_q.ien <= VRC_IRQ_RST[VRC_IEN_BIT];
			st_q.rsen <= VRC_IRQ_RST[VRC_RSEN_BIT];
		end
		else
		begin
			st_q <= st_d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign prdata = st_q.rdata;
	assign pready = st_q.ready;
	assign pslverr = st_q.err;
	assign regulator_enable_bit = st_q.ren;
	assign regulator_low_power_select = st_q.mode;
	assign vbus_irq = st_q.irq;
	assign usb_sys_reset = st_q.srst;

endmodule

// *** verif/vrc_checker.sv ***
`timescale 1ns/10ps
module vrc_chk (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic vbus_in,
	input wire logic vbus_irq,
	input wire logic usb_sys_reset,
	input wire logic regulator_enable_bit
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// quiet bus and steady vbus, so outputs must have settled
	sequence s_q; !psel && $stable(vbus_in); endsequence
	property p_rdy; psel && !penable |=> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("late ready");
	property p_one; pready |=> !pready; endproperty
	a_one: assert property (p_one) else $error("long ready");
	property p_rst;
		$fell(rst) |-> regulator_enable_bit && !vbus_irq && !usb_sys_reset;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state");
	property p_en; $changed(regulator_enable_bit) |-> $past(penable); endproperty
	a_en: assert property (p_en) else $error("enable moved");
	property p_irq; s_q[*6] |-> $stable(vbus_irq); endproperty
	a_irq: assert property (p_irq) else $error("irq moved");
	property p_sr; s_q[*6] |-> $stable(usb_sys_reset); endproperty
	a_sr: assert property (p_sr) else $error("sysrst moved");
	property p_drop;
		s_q[*4] ##1 vbus_irq && !psel && $changed(vbus_in) ##1 s_q[*4]
			|=> !vbus_irq;
	endproperty
	a_drop: assert property (p_drop) else $error("irq held");
	property p_sdrop;
		s_q[*4] ##1 usb_sys_reset && !psel && $changed(vbus_in)
			##1 s_q[*4] |=> !usb_sys_reset;
	endproperty
	a_sdrop: assert property (p_sdrop) else $error("sysrst held");
endmodule
bind vrc_top vrc_chk i_chk (.*);

// *** verif/vrc_host.sv ***
`timescale 1ns/10ps
module vrc_host (
	input wire logic clk,
	input wire logic attach,
	output logic     vbus_in = 1'b0
);
	// supply ramps slowly, so the level only moves on a clock edge
	always @(posedge clk)
		vbus_in <= attach;
endmodule

// *** verif/vrc_top_tb.sv ***
`timescale 1ns/10ps
module vrc_top_tb;
	logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, attach = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata;
	logic pready, pslverr, regulator_enable_bit, vbus_in;
	logic regulator_low_power_select, vbus_irq, usb_sys_reset;
	int bad_count = 0, checks_done = 0;
	vrc_top i_dut (.*);
	vrc_host i_host (.*);
	initial forever #12.5 clk = ~clk;
	task chk(string n, logic [31:0] s, logic [31:0] x);
		checks_done++;
		if (s !== x)
		begin
			bad_count++;
			$display("[FAIL] %s exp %h got %h", n, x, s);
		end
	endtask
	task xf(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1);
		if (!w)
			chk("rdata", prdata, d);
		chk("slverr", pslverr, a > 4);
		psel <= 0;
		penable <= 0;
	endtask
	task cs(logic v, logic [31:0] c, g, logic i, s);
		xf(1, 8'h00, c);
		xf(1, 8'h04, g);
		xf(0, 8'h04, g);
		repeat (5) @(posedge clk);
		attach <= v;
		repeat (6) @(posedge clk);
		xf(0, 8'h00, {c[31:7], v, c[5:0]});
		chk("outs", {regulator_enable_bit, regulator_low_power_select,
			vbus_irq, usb_sys_reset}, {!c[7], c[4], i, s});
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		repeat (2000) @(posedge clk);
		bad_count++;
		tally_and_finish;
	end
	initial
	begin
		repeat (12) @(posedge clk);
		rst <= 0;
		cs(0, 0, 0, 0, 0);
		cs(0, 32'h0000_0090, 0, 0, 0);
		cs(1, 32'h0000_0020, 3, 1, 1);
		cs(0, 32'h0000_0020, 3, 0, 0);
		cs(0, 0, 3, 1, 1);
		cs(0, 0, 2, 0, 1);
		xf(0, 8'h08, 0);
		tally_and_finish;
	end
endmodule
